// ==== spg_drive_model.sv ====
// drive-side model: counts and times pulses on one axis
`timescale 1ns/1ps
module spg_drive_model (
  input  wire logic clock_i,
  input  wire logic clr_i,
  input  wire logic a_i,
  input  wire logic b_i,
  output int        rises_a,
  output int        rises_b,
  output int        hi_min,
  output int        hi_max,
  output int        lo_min,
  output int        gap_min,
  output int        quad_bad,
  output int        quad_moves
);
  logic pa;
  logic pb;
  int   hi;
  int   lo;
  int   gap;
  // a drive sees levels only; widths counted in clock samples
  always @(posedge clock_i) begin
    if (clr_i) begin
      rises_a = 0;
      rises_b = 0;
      hi_min = 999;
      hi_max = 0;
      lo_min = 999;
      gap_min = 999;
      quad_bad = 0;
      quad_moves = 0;
      hi = 0;
      lo = -1;
      gap = -1;
    end else begin
      if (a_i && !pa) rises_a++;
      if (b_i && !pb) rises_b++;
      if (a_i) hi++;
      if (!a_i && lo >= 0) lo++;
      if (gap >= 0) gap++;
      if (a_i && !pa && lo > 0) lo_min = (lo < lo_min) ? lo : lo_min;
      if (a_i && !pa) lo = -1;
      if (!a_i && pa) begin
        hi_min = (hi < hi_min) ? hi : hi_min;
        hi_max = (hi > hi_max) ? hi : hi_max;
        hi = 0;
        lo = 1;
        gap = 0;
      end
      if (b_i != pb && gap >= 0) gap_min = (gap < gap_min) ? gap : gap_min;
      // positive quadrature successor is {~b, a}
      if ({a_i, b_i} != {pa, pb}) begin
        quad_moves++;
        if ({a_i, b_i} != {~pb, pa}) quad_bad++;
      end
    end
    pa = a_i;
    pb = b_i;
  end
endmodule

// ==== spg_params.svh ====
// constants for the six-axis step pulse generator: timing, register offsets, field positions
`ifndef SPG_PARAMS_SVH
`define SPG_PARAMS_SVH

`define SPG_NUM_AXES       6
`define SPG_CLK_HZ         32'd100000000
`define SPG_CLK_PERIOD_NS  32'd10
`define SPG_US_NS          32'd1000
`define SPG_US_CYC         (`SPG_US_NS / `SPG_CLK_PERIOD_NS)
`define SPG_ACC_TICK_SHIFT 10
`define SPG_ACC_TICK_CYC   (`SPG_CLK_HZ >> `SPG_ACC_TICK_SHIFT)
`define SPG_POS_GAIN_SHIFT 6
`define SPG_FRAC_BITS      16
`define SPG_RATE_MAX       48'sh000002FAF080

`define SPG_GLOBAL_AXIS    3'h7
`define SPG_REG_CFG        4'h0
`define SPG_REG_POS_CMD    4'h1
`define SPG_REG_VEL_CMD    4'h2
`define SPG_REG_MAXVEL     4'h3
`define SPG_REG_MAXACC     4'h4
`define SPG_REG_SCALE      4'h5
`define SPG_REG_STEPLEN    4'h6
`define SPG_REG_STEPSPACE  4'h7
`define SPG_REG_DIRDELAY   4'h8
`define SPG_REG_STEP_TOTAL_FEEDBACK   4'h9
`define SPG_REG_POS_FB     4'hA
`define SPG_REG_PWR_CTL    4'h0
`define SPG_REG_WD_TIMEOUT 4'h1
`define SPG_REG_WD_KICK    4'h2
`define SPG_REG_STATUS     4'h3

`define SPG_PWR_HOST       0
`define SPG_PWR_WDEN       1
`define SPG_STAT_EXPIRED   0
`define SPG_STAT_FAULT     1
`define SPG_STAT_POWER     2
`define SPG_CFG_W          6

`endif

// ==== spg_pkg.sv ====
// types shared by the step pulse generator
package spg_pkg;

  typedef enum logic [1:0] {
    SPG_FMT_STEP_DIR,
    SPG_FMT_UP_DOWN,
    SPG_FMT_QUAD
  } spg_fmt_e;

  typedef struct packed {
    logic     invert_channel_two;
    logic     invert_channel_one;
    logic     ctrl_velocity;
    spg_fmt_e fmt;
    logic     enable;
  } spg_cfg_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spg_bus_s;

  typedef enum logic [1:0] {
    SPG_ST_IDLE,
    SPG_ST_DIRSET,
    SPG_ST_PULSE,
    SPG_ST_SPACE
  } spg_state_e;

endpackage

// ==== spg_step_pulse_generator.sv ====
// six-axis step pulse generator with per-axis registers, watchdog and power enable
`timescale 1ns/1ps
`include "spg_params.svh"

module spg_step_pulse_generator
  import spg_pkg::*;
#(
  parameter int unsigned ACC_TICK_CYC = `SPG_ACC_TICK_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        power_fault_i,
  output logic      [31:0] rdata_o,
  output logic      [5:0]  chan_one_o,
  output logic      [5:0]  chan_two_o,
  output logic             axis_power_en_o,
  output logic             bus_power_en_o
);

  localparam int N = `SPG_NUM_AXES;

  // signed Q16.16 times unsigned steps-per-unit, back to whole steps
  function automatic logic signed [47:0] scale_mul(input logic signed [31:0] q,
                                                   input logic [31:0] s);
    logic signed [64:0] p;
    p = q * $signed({1'b0, s});
    return p[`SPG_FRAC_BITS +: 48];
  endfunction

  // nanoseconds to whole clock cycles, rounded up, never below one
  function automatic logic [31:0] ns_to_cyc(input logic [31:0] ns);
    logic [32:0] c;
    c = ({1'b0, ns} + {1'b0, `SPG_CLK_PERIOD_NS} - 33'd1) / {1'b0, `SPG_CLK_PERIOD_NS};
    return (c == 33'd0) ? 32'd1 : c[31:0];
  endfunction

  // clamp a signed rate to a positive bound
  function automatic logic signed [47:0] clamp(input logic signed [47:0] v,
                                               input logic signed [47:0] lim);
    if (v > lim) return lim;
    if (v < -lim) return -lim;
    return v;
  endfunction

  spg_bus_s bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // address split: upper bits pick the axis (7 is global), lower the register
  wire logic [2:0] sel_axis   = bus.addr[6:4];
  wire logic [3:0] sel_reg    = bus.addr[3:0];
  wire logic       sel_global = (sel_axis == `SPG_GLOBAL_AXIS) && !bus.addr[7];
  wire logic       sel_valid  = (sel_axis < 3'(N)) && !bus.addr[7];

  // per-axis host registers
  spg_cfg_s           cfg       [N];
  logic signed [31:0] pos_cmd   [N];
  logic signed [31:0] vel_cmd   [N];
  logic        [31:0] maxvel    [N];
  logic        [31:0] maxacc    [N];
  logic        [31:0] scale     [N];
  logic        [31:0] steplen   [N];
  logic        [31:0] stepspace [N];
  logic        [31:0] dirdelay  [N];

  // per-axis generator state
  spg_state_e         st        [N];
  logic signed [31:0] count     [N];
  logic signed [47:0] cur_rate  [N];
  logic        [31:0] acc       [N];
  logic               pending   [N];
  logic               dir_fwd   [N];
  logic        [1:0]  phase     [N];
  logic        [31:0] tmr       [N];
  logic        [31:0] since     [N];

  // global power and watchdog
  logic        pwr_host;
  logic        wd_en;
  logic [31:0] wd_timeout;
  logic [31:0] wd_cnt;
  logic [31:0] us_cnt;
  logic        wd_expired;
  logic [31:0] tick_cnt;

  wire logic acc_tick = (tick_cnt == ACC_TICK_CYC - 1);
  wire logic us_tick  = (us_cnt == `SPG_US_CYC - 1);
  wire logic wd_kick  = bus.wr && sel_global && (sel_reg == `SPG_REG_WD_KICK);
  // the tick that completes the last whole microsecond expires the watchdog
  wire logic wd_hit   = wd_en && us_tick && ((wd_cnt + 32'h1) >= wd_timeout);

  // rate demand per axis: loop select, limits, timing conversions
  logic signed [47:0] demand   [N];
  logic signed [47:0] acc_step [N];
  logic        [31:0] rate_abs [N];
  logic               want_fwd [N];
  logic        [31:0] len_cyc  [N];
  logic        [31:0] spc_cyc  [N];
  logic        [31:0] dd_cyc   [N];
  logic               raw1     [N];
  logic               raw2     [N];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      logic signed [47:0] target;
      logic signed [47:0] pos_dem;
      logic signed [47:0] d;
      logic signed [47:0] a;
      target  = scale_mul(pos_cmd[i], scale[i]);
      pos_dem = (target - 48'(count[i])) <<< `SPG_POS_GAIN_SHIFT;
      d = cfg[i].ctrl_velocity ? scale_mul(vel_cmd[i], scale[i]) : pos_dem;
      if (maxvel[i] != 32'h0) begin
        d = clamp(d, scale_mul(maxvel[i], scale[i]));
      end
      demand[i] = clamp(d, `SPG_RATE_MAX);
      a = scale_mul(maxacc[i], scale[i]) >>> `SPG_ACC_TICK_SHIFT;
      acc_step[i] = (a < 48'sh1) ? 48'sh1 : a;
      rate_abs[i] = (cur_rate[i] < 0) ? 32'(-cur_rate[i]) : 32'(cur_rate[i]);
      want_fwd[i] = (cur_rate[i] >= 0);
      len_cyc[i]  = ns_to_cyc(steplen[i]);
      spc_cyc[i]  = ns_to_cyc(stepspace[i]);
      dd_cyc[i]   = ns_to_cyc(dirdelay[i]);
    end
  end

  // channel shaping per format, before inversion
  always_comb begin
    for (int i = 0; i < N; i++) begin
      unique case (cfg[i].fmt)
        SPG_FMT_STEP_DIR: begin
          raw1[i] = (st[i] == SPG_ST_PULSE);
          raw2[i] = dir_fwd[i];
        end
        SPG_FMT_UP_DOWN: begin
          raw1[i] = (st[i] == SPG_ST_PULSE) && dir_fwd[i];
          raw2[i] = (st[i] == SPG_ST_PULSE) && !dir_fwd[i];
        end
        SPG_FMT_QUAD: begin
          raw1[i] = phase[i][1] ^ phase[i][0];
          raw2[i] = phase[i][1];
        end
        default: begin
          raw1[i] = 1'b0;
          raw2[i] = 1'b0;
        end
      endcase
    end
  end

  // host writes; commands refreshed by software each servo period
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < N; i++) begin
        cfg[i]       <= '0;
        pos_cmd[i]   <= '0;
        vel_cmd[i]   <= '0;
        maxvel[i]    <= '0;
        maxacc[i]    <= '0;
        scale[i]     <= '0;
        steplen[i]   <= '0;
        stepspace[i] <= '0;
        dirdelay[i]  <= '0;
      end
      pwr_host   <= 1'b0;
      wd_en      <= 1'b0;
      wd_timeout <= '0;
    end else if (bus.wr && sel_valid) begin
      unique case (sel_reg)
        `SPG_REG_CFG:       cfg[sel_axis]       <= spg_cfg_s'(bus.wdata[`SPG_CFG_W-1:0]);
        `SPG_REG_POS_CMD:   pos_cmd[sel_axis]   <= bus.wdata;
        `SPG_REG_VEL_CMD:   vel_cmd[sel_axis]   <= bus.wdata;
        `SPG_REG_MAXVEL:    maxvel[sel_axis]    <= bus.wdata;
        `SPG_REG_MAXACC:    maxacc[sel_axis]    <= bus.wdata;
        `SPG_REG_SCALE:     scale[sel_axis]     <= bus.wdata;
        `SPG_REG_STEPLEN:   steplen[sel_axis]   <= bus.wdata;
        `SPG_REG_STEPSPACE: stepspace[sel_axis] <= bus.wdata;
        `SPG_REG_DIRDELAY:  dirdelay[sel_axis]  <= bus.wdata;
        default: ;
      endcase
    end else if (bus.wr && sel_global) begin
      if (sel_reg == `SPG_REG_PWR_CTL) begin
        pwr_host <= bus.wdata[`SPG_PWR_HOST];
        wd_en    <= bus.wdata[`SPG_PWR_WDEN];
      end
      if (sel_reg == `SPG_REG_WD_TIMEOUT) begin
        wd_timeout <= bus.wdata;
      end
    end
  end

  // velocity ramp: follows demand at once, or by bounded steps each tick
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      tick_cnt <= '0;
      for (int i = 0; i < N; i++) cur_rate[i] <= '0;
    end else begin
      tick_cnt <= acc_tick ? 32'h0 : tick_cnt + 32'h1;
      for (int i = 0; i < N; i++) begin
        if (!cfg[i].enable) begin
          cur_rate[i] <= '0;
        end else if (maxacc[i] == 32'h0) begin
          cur_rate[i] <= demand[i];
        end else if (acc_tick) begin
          if (demand[i] > cur_rate[i] + acc_step[i]) begin
            cur_rate[i] <= cur_rate[i] + acc_step[i];
          end else if (demand[i] < cur_rate[i] - acc_step[i]) begin
            cur_rate[i] <= cur_rate[i] - acc_step[i];
          end else begin
            cur_rate[i] <= demand[i];
          end
        end
      end
    end
  end

  // per-axis phase accumulator and pulse sequencer, independent of the host
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < N; i++) begin
        st[i]      <= SPG_ST_IDLE;
        count[i]   <= '0;
        acc[i]     <= '0;
        pending[i] <= 1'b0;
        dir_fwd[i] <= 1'b1;
        phase[i]   <= '0;
        tmr[i]     <= '0;
        since[i]   <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        logic start;
        logic acc_wrap;
        start    = (st[i] == SPG_ST_IDLE) && pending[i] && cfg[i].enable
                   && (want_fwd[i] == dir_fwd[i]);
        acc_wrap = (acc[i] + rate_abs[i] >= `SPG_CLK_HZ);
        // accumulator: the step request set wins over its consumption
        if (!cfg[i].enable) begin
          acc[i]     <= '0;
          pending[i] <= 1'b0;
        end else begin
          acc[i]     <= acc_wrap ? acc[i] + rate_abs[i] - `SPG_CLK_HZ : acc[i] + rate_abs[i];
          pending[i] <= acc_wrap || (pending[i] && !start);
        end
        if (since[i] != 32'hFFFFFFFF && st[i] != SPG_ST_PULSE) since[i] <= since[i] + 32'h1;
        unique case (st[i])
          SPG_ST_IDLE: begin
            if (start) begin
              st[i]    <= SPG_ST_PULSE;
              tmr[i]   <= len_cyc[i] - 32'h1;
              count[i] <= dir_fwd[i] ? count[i] + 32'sh1 : count[i] - 32'sh1;
              phase[i] <= dir_fwd[i] ? phase[i] + 2'h1 : phase[i] - 2'h1;
            end else if (pending[i] && cfg[i].enable && since[i] >= dd_cyc[i]) begin
              dir_fwd[i] <= want_fwd[i];
              st[i]      <= SPG_ST_DIRSET;
              tmr[i]     <= dd_cyc[i] - 32'h1;
            end
          end
          SPG_ST_DIRSET: begin
            if (tmr[i] == 32'h0) st[i] <= SPG_ST_IDLE;
            else tmr[i] <= tmr[i] - 32'h1;
          end
          SPG_ST_PULSE: begin
            if (tmr[i] == 32'h0) begin
              st[i]    <= SPG_ST_SPACE;
              tmr[i]   <= spc_cyc[i] - 32'h1;
              since[i] <= '0;
            end else begin
              tmr[i] <= tmr[i] - 32'h1;
            end
          end
          SPG_ST_SPACE: begin
            if (tmr[i] == 32'h0) st[i] <= SPG_ST_IDLE;
            else tmr[i] <= tmr[i] - 32'h1;
          end
        endcase
      end
    end
  end

  // registered channel outputs with per-axis inversion
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      chan_one_o <= '0;
      chan_two_o <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        chan_one_o[i] <= raw1[i] ^ cfg[i].invert_channel_one;
        chan_two_o[i] <= raw2[i] ^ cfg[i].invert_channel_two;
      end
    end
  end

  // watchdog in microseconds; expiry is sticky until the next kick or until the watchdog is disabled
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      us_cnt     <= '0;
      wd_cnt     <= '0;
      wd_expired <= 1'b0;
    end else begin
      us_cnt <= (us_tick || wd_kick) ? 32'h0 : us_cnt + 32'h1;
      if (wd_kick || !wd_en) wd_cnt <= '0;
      else if (us_tick && wd_cnt != 32'hFFFFFFFF) wd_cnt <= wd_cnt + 32'h1;
      wd_expired <= wd_hit || (wd_expired && !wd_kick && wd_en);
    end
  end

  // power gating: no software path can bypass the watchdog or fault term
  wire logic power_ok = pwr_host && !wd_expired && !power_fault_i;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      axis_power_en_o <= 1'b0;
      bus_power_en_o  <= 1'b0;
    end else begin
      axis_power_en_o <= power_ok;
      bus_power_en_o  <= power_ok;
    end
  end

  // readback: one shared divider serves the addressed axis only, to save area
  wire logic signed [31:0] rd_count = sel_valid ? count[sel_axis] : 32'sh0;
  wire logic        [31:0] rd_scale = sel_valid ? scale[sel_axis] : 32'h0;
  wire logic signed [47:0] rd_num   = 48'(rd_count) <<< `SPG_FRAC_BITS;
  wire logic signed [47:0] rd_quot  = (rd_scale == 32'h0) ? 48'sh0
                                      : rd_num / $signed({16'h0, rd_scale});
  logic [31:0] rd_axis_val;
  logic [31:0] rd_glob_val;

  always_comb begin
    rd_axis_val = 32'h0;
    if (sel_valid) begin
      unique case (sel_reg)
        `SPG_REG_CFG:       rd_axis_val = 32'(cfg[sel_axis]);
        `SPG_REG_POS_CMD:   rd_axis_val = pos_cmd[sel_axis];
        `SPG_REG_VEL_CMD:   rd_axis_val = vel_cmd[sel_axis];
        `SPG_REG_MAXVEL:    rd_axis_val = maxvel[sel_axis];
        `SPG_REG_MAXACC:    rd_axis_val = maxacc[sel_axis];
        `SPG_REG_SCALE:     rd_axis_val = scale[sel_axis];
        `SPG_REG_STEPLEN:   rd_axis_val = steplen[sel_axis];
        `SPG_REG_STEPSPACE: rd_axis_val = stepspace[sel_axis];
        `SPG_REG_DIRDELAY:  rd_axis_val = dirdelay[sel_axis];
        `SPG_REG_STEP_TOTAL_FEEDBACK:  rd_axis_val = rd_count;
        `SPG_REG_POS_FB:    rd_axis_val = rd_quot[31:0];
        default:            rd_axis_val = 32'h0;
      endcase
    end
    rd_glob_val = 32'h0;
    if (sel_reg == `SPG_REG_PWR_CTL) begin
      rd_glob_val[`SPG_PWR_HOST] = pwr_host;
      rd_glob_val[`SPG_PWR_WDEN] = wd_en;
    end else if (sel_reg == `SPG_REG_WD_TIMEOUT) begin
      rd_glob_val = wd_timeout;
    end else if (sel_reg == `SPG_REG_STATUS) begin
      rd_glob_val[`SPG_STAT_EXPIRED] = wd_expired;
      rd_glob_val[`SPG_STAT_FAULT]   = power_fault_i;
      rd_glob_val[`SPG_STAT_POWER]   = axis_power_en_o;
    end
  end

  // read data valid exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (bus.rd) begin
      rdata_o <= sel_global ? rd_glob_val : rd_axis_val;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// ==== spg_step_pulse_generator_props.sv ====
// port-level assertions for the step pulse generator
`timescale 1ns/1ps
module spg_step_pulse_generator_props #(
  parameter int unsigned ACC_TICK_CYC = 100
) (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        power_fault_i,
  input wire logic [31:0] rdata_o,
  input wire logic [5:0]  chan_one_o,
  input wire logic [5:0]  chan_two_o,
  input wire logic        axis_power_en_o,
  input wire logic        bus_power_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic       never_en;
  logic [1:0] inv_sh;
  logic [1:0] calm;
  wire        cfg0_wr = wr_i && (addr_i == 8'h00);
  // shadow of axis 0 config: predicts step/dir idle levels until first enable
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      never_en <= 1'b1;
      inv_sh   <= 2'h0;
      calm     <= 2'h0;
    end else if (cfg0_wr) begin
      never_en <= never_en && !wdata_i[0];
      inv_sh   <= wdata_i[5:4];
      calm     <= 2'h0;
    end else if (calm != 2'h3) begin
      calm <= calm + 2'h1;
    end
  end
  sequence s_fault_hold;
    power_fault_i ##1 power_fault_i;
  endsequence
  sequence s_bad_rd;
    rd_i && (addr_i[7] || (addr_i[6:4] == 3'h6));
  endsequence
  property p_fault_off;
    power_fault_i |=> !axis_power_en_o;
  endproperty
  property p_fault_hold;
    s_fault_hold |=> !axis_power_en_o && !bus_power_en_o;
  endproperty
  property p_bus_pair;
    axis_power_en_o == bus_power_en_o;
  endproperty
  property p_rise_cause;
    $rose(axis_power_en_o) |-> !$past(power_fault_i);
  endproperty
  property p_release_lag;
    $fell(power_fault_i) |-> !axis_power_en_o;
  endproperty
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  property p_unmapped;
    s_bad_rd |=> rdata_o == 32'h0;
  endproperty
  property p_unused_reg;
    rd_i && (addr_i[6:4] != 3'h7) && (addr_i[3:0] > 4'hA) |=> rdata_o == 32'h0;
  endproperty
  property p_idle_levels;
    never_en && (calm == 2'h3) |-> chan_one_o[0] == inv_sh[0] && chan_two_o[0] == !inv_sh[1];
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("power on during fault");
  a_fault_hold: assert property (p_fault_hold) else $error("power on in fault");
  a_bus_pair: assert property (p_bus_pair) else $error("power outputs differ");
  a_rise_cause: assert property (p_rise_cause) else $error("power rose in fault");
  a_release_lag: assert property (p_release_lag) else $error("power too early");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("absent axis answered");
  a_unused_reg: assert property (p_unused_reg) else $error("unused register answered");
  a_idle_levels: assert property (p_idle_levels) else $error("idle level wrong");
endmodule

bind spg_step_pulse_generator spg_step_pulse_generator_props #(
  .ACC_TICK_CYC(ACC_TICK_CYC)
) spg_step_pulse_generator_props_inst (.*);

// ==== spg_step_pulse_generator_tb_top.sv ====
// self-checking bench for the step pulse generator
`timescale 1ns/1ps
module spg_step_pulse_generator_tb_top;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        power_fault_i = 1'b0;
  logic        clr = 1'b1;
  logic [31:0] rdata_o;
  logic [5:0]  chan_one_o;
  logic [5:0]  chan_two_o;
  logic        axis_power_en_o;
  logic        bus_power_en_o;
  int          ra, rb, hmin, hmax, lmin, gmin, qbad, qmov, n1, n2;
  int          err_total = 0;
  int          total_checks = 0;
  logic [31:0] mdl [0:127];
  logic [31:0] seed = 32'hFDB1;
  logic [31:0] v;

  spg_step_pulse_generator #(.ACC_TICK_CYC(100)) spg_step_pulse_generator_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .power_fault_i(power_fault_i), .rdata_o(rdata_o),
    .chan_one_o(chan_one_o), .chan_two_o(chan_two_o),
    .axis_power_en_o(axis_power_en_o), .bus_power_en_o(bus_power_en_o));
  spg_drive_model spg_drive_model_inst (
    .clock_i(clock_i), .clr_i(clr), .a_i(chan_one_o[0]), .b_i(chan_two_o[0]),
    .rises_a(ra), .rises_b(rb), .hi_min(hmin), .hi_max(hmax), .lo_min(lmin),
    .gap_min(gmin), .quad_bad(qbad), .quad_moves(qmov));

  always #5 clock_i = ~clock_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // step counts depend on accumulator phase, so one step either way is allowed
  task automatic near(input int seen, input int exp);
    check({31'h0, (seen >= exp - 1) && (seen <= exp + 1)}, 32'h1);
  endtask
  // register model: read-only and unmapped places never change
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    if (!a[7] && a[6:4] < 3'h6 && a[3:0] <= 4'h8) mdl[a] = (a[3:0] == 4'h0) ? (d & 32'h3F) : d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic clear;
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
  endtask
  task automatic setfault(input logic f);
    @(posedge clock_i);
    power_fault_i <= f;
    run(2);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 128; i++) mdl[i] = 32'h0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // reset values and the absent seventh axis
    for (int i = 0; i < 112; i++) begin
      rd(i[7:0]);
      check(v, mdl[i]);
    end
    rd(8'hC5);
    check(v, 32'h0);
    $display("test map done");
    // random words in all seven axis blocks but the config registers, including read-only and absent places
    for (int i = 0; i < 112; i++) begin
      seed = lfsr(seed);
      if (i[3:0] != 4'h0) wr(i[7:0], seed);
    end
    for (int i = 0; i < 112; i++) begin
      rd(i[7:0]);
      check(v, mdl[i]);
    end
    $display("test regs done");
    // power gating by host bit, fault and watchdog
    wr(8'h70, 32'h1);
    run(2);
    check(axis_power_en_o, 32'h1);
    rd(8'h73);
    check(v, 32'h4);
    setfault(1'b1);
    check(axis_power_en_o, 32'h0);
    rd(8'h73);
    check(v, 32'h2);
    setfault(1'b0);
    check(axis_power_en_o, 32'h1);
    wr(8'h71, 32'h2);
    wr(8'h70, 32'h3);
    run(100);
    wr(8'h72, 32'h0);
    run(150);
    check(axis_power_en_o, 32'h1);
    run(100);
    check(axis_power_en_o, 32'h0);
    rd(8'h73);
    check(v, 32'h1);
    wr(8'h72, 32'h0);
    run(2);
    check(axis_power_en_o, 32'h1);
    wr(8'h70, 32'h0);
    run(2);
    check(axis_power_en_o, 32'h0);
    $display("test power done");
    // inversion of idle levels on axis 0
    wr(8'h00, 32'h10);
    run(3);
    check(chan_one_o[0], 32'h1);
    wr(8'h00, 32'h30);
    run(3);
    check(chan_two_o[0], 32'h0);
    wr(8'h00, 32'h0);
    run(3);
    check({chan_one_o[0], chan_two_o[0]}, 32'h1);
    $display("test invert done");
    // step/dir velocity run: 1000 units/s at 1000 steps/unit, one step per 100 cycles
    wr(8'h05, 32'd1000);
    wr(8'h02, 32'h03E80000);
    wr(8'h06, 32'd50);
    wr(8'h07, 32'd100);
    wr(8'h08, 32'd200);
    wr(8'h03, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h9);
    clear;
    run(2000);
    wr(8'h00, 32'h8);
    run(50);
    n1 = ra;
    near(n1, 20);
    check(hmin, 32'd5);
    check(hmax, 32'd5);
    check({31'h0, lmin >= 10}, 32'h1);
    rd(8'h09);
    check(v, n1);
    rd(8'h0A);
    check(v, n1 * 65536 / 1000);
    run(500);
    check(ra, n1);
    wr(8'h02, 32'hFC180000);
    wr(8'h00, 32'h9);
    run(1000);
    wr(8'h00, 32'h8);
    run(50);
    n2 = ra - n1;
    near(n2, 10);
    rd(8'h09);
    check(v, n1 - n2);
    check({31'h0, gmin >= 20}, 32'h1);
    $display("test stepdir done");
    // velocity clamp: 100 units/s gives one step per 1000 cycles
    wr(8'h02, 32'h03E80000);
    wr(8'h03, 32'h00640000);
    clear;
    wr(8'h00, 32'h9);
    run(5000);
    wr(8'h00, 32'h8);
    run(50);
    near(ra, 5);
    // acceleration limit: ramp from rest keeps the step count well below 20
    wr(8'h03, 32'h0);
    wr(8'h04, 32'h7FFF0000);
    clear;
    wr(8'h00, 32'h9);
    run(2000);
    wr(8'h00, 32'h8);
    run(50);
    check({31'h0, (ra >= 4) && (ra <= 8)}, 32'h1);
    wr(8'h04, 32'h0);
    $display("test maxvel done");
    // up/down: positive motion pulses channel one only
    wr(8'h03, 32'h0);
    wr(8'h00, 32'hB);
    run(5);
    clear;
    run(1000);
    wr(8'h00, 32'hA);
    run(50);
    near(ra, 10);
    check(rb, 32'h0);
    // quadrature: one gray step per step, A leading
    wr(8'h00, 32'hD);
    run(5);
    clear;
    run(1000);
    wr(8'h00, 32'hC);
    run(50);
    check(qbad, 32'h0);
    near(qmov, 10);
    $display("test quad done");
    stop_test;
  end

  // cut a hang short
  initial begin
    repeat (60000) @(posedge clock_i);
    err_total++;
    stop_test;
  end
endmodule
